/* File: inc/otpos_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz mclk
// Notes:   Definitions only
`ifndef OTPOS_CFG_SVH
`define OTPOS_CFG_SVH

`define OTPOS_ADDR_ZERO_HI    8'h01
`define OTPOS_ADDR_ZERO_LO    8'h02
`define OTPOS_ADDR_MAXANG_HI  8'h05
`define OTPOS_ADDR_MAXANG_LO  8'h06
`define OTPOS_ADDR_SETTINGS   8'h07
`define OTPOS_ADDR_ANGLE_HI   8'h0e
`define OTPOS_ADDR_ANGLE_LO   8'h0f
`define OTPOS_ADDR_BURN_CMD   8'hff

`define OTPOS_CMD_RELOAD_1    8'h01
`define OTPOS_CMD_RELOAD_2    8'h11
`define OTPOS_CMD_RELOAD_3    8'h10
`define OTPOS_CMD_COMMIT      8'h40

`define OTPOS_OSS_LSB         4
`define OTPOS_OSS_MSB         5
`define OTPOS_OSS_PWM         2'h2

`define OTPOS_RST_MAXANG      12'h000
`define OTPOS_RST_SETTINGS    8'h00
`define OTPOS_RST_ZERO        12'h000

`define OTPOS_CLK_PERIOD_NS   10
`define OTPOS_APPLY_DELAY_NS  1000000
`define OTPOS_PIN_LOW_MS      100
`define OTPOS_APPLY_CYCLES    ((`OTPOS_APPLY_DELAY_NS + `OTPOS_CLK_PERIOD_NS - 1) / `OTPOS_CLK_PERIOD_NS)
`define OTPOS_PIN_LOW_CYCLES  ((`OTPOS_PIN_LOW_MS * 1000000 + `OTPOS_CLK_PERIOD_NS - 1) / `OTPOS_CLK_PERIOD_NS)

`endif

/* File: inc/otpos_pkg.sv */
// Purpose: Types for the nonvolatile access and output select block
// Assumes: Constants live in otpos_cfg.svh
// Notes:   One-hot reload sequence states
package otpos_pkg;
    typedef enum logic [2:0] {
        RELOAD_IDLE  = 3'h1,
        RELOAD_GOT1  = 3'h2,
        RELOAD_GOT2  = 3'h4
    } otpos_reload_t;
endpackage

/* File: rtl/otpos_core.sv */
// Purpose: Nonvolatile reload, settings commit, pin zero burn, output select
// Assumes: Register port is the decoded byte access of the serial interface
// Notes:   Analog and PWM waveform generation sits outside this block
// Functional notes
// - Bytes 01,11,10 to 0xff reload storage
// - Output pin driven low forever after burn
// - New configuration reaches output after 1 ms
// - Output stage select picks analog or PWM
// - PWM mode powers down the DAC
// - Angle readable at any time
`timescale 1ns/1ns
`include "otpos_cfg.svh"
module otpos_core #(
    parameter int unsigned APPLY_CYCLES   = `OTPOS_APPLY_CYCLES,
    parameter int unsigned PIN_LOW_CYCLES = `OTPOS_PIN_LOW_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic [11:0] angleIn,
    input  wire logic        outPinIn,
    input  wire logic        programOptionPin,
    output logic      [7:0]  regRdData,
    output logic             regRdValid,
    output logic             outPinOut,
    output logic             outPinOe_n,
    output logic      [1:0]  outputStageSelect,
    output logic             pwmSelect,
    output logic             dacPowerDown,
    output logic             reloadPulse,
    output logic             zeroBurnPulse,
    output logic      [11:0] zeroPosition
);
    // Pin synchronisers
    logic [2:0] outSync_q, outSync_d;
    logic [2:0] pgoSync_q, pgoSync_d;
    logic       outLvl_q, outLvl_d;
    logic       pgoLvl_q, pgoLvl_d;

    always_comb begin
        outSync_d = {outSync_q[1:0], outPinIn};
        pgoSync_d = {pgoSync_q[1:0], programOptionPin};
        outLvl_d  = (outSync_q[1] == outSync_q[2]) ? outSync_q[2] : outLvl_q;
        pgoLvl_d  = (pgoSync_q[1] == pgoSync_q[2]) ? pgoSync_q[2] : pgoLvl_q;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            outSync_q <= 3'h7;
            pgoSync_q <= 3'h7;
            outLvl_q  <= 1'b1;
            pgoLvl_q  <= 1'b1;
        end else begin
            outSync_q <= outSync_d;
            pgoSync_q <= pgoSync_d;
            outLvl_q  <= outLvl_d;
            pgoLvl_q  <= pgoLvl_d;
        end
    end

    // Main state
    otpos_pkg::otpos_reload_t reload_q, reload_d;
    logic [11:0] maxAng_q, maxAng_d, nvMaxAng_d;
    logic [7:0]  settings_q, settings_d, nvSettings_d;
    // Blank storage at power-up; srst does not erase it
    logic [11:0] nvMaxAng_q   = `OTPOS_RST_MAXANG;
    logic [7:0]  nvSettings_q = `OTPOS_RST_SETTINGS;
    logic [31:0] applyCnt_q, applyCnt_d;
    logic [31:0] lowCnt_q, lowCnt_d;
    logic        lowQual_q, lowQual_d;
    // Burnt zero is permanent, kept across srst
    logic        zeroBurnt_q  = 1'b0;
    logic [11:0] zero_q       = `OTPOS_RST_ZERO;
    logic        zeroBurnt_d;
    logic [11:0] zero_d;
    logic [1:0]  stage_q, stage_d;
    logic [7:0]  rdData_q, rdData_d;
    logic        rdValid_q, rdValid_d;
    logic        reload_p_q, reload_p_d;
    logic        burn_p_q, burn_p_d;
    logic        pwm_q, pwm_d, dacOff_q, dacOff_d;
    logic        cmdWr;

    always_comb begin
        cmdWr        = regWrEn && (regAddr == `OTPOS_ADDR_BURN_CMD);
        reload_d     = reload_q;
        maxAng_d     = maxAng_q;
        settings_d   = settings_q;
        nvMaxAng_d   = nvMaxAng_q;
        nvSettings_d = nvSettings_q;
        applyCnt_d   = (applyCnt_q != 32'h0) ? applyCnt_q - 32'h1 : 32'h0;
        lowCnt_d     = lowCnt_q;
        lowQual_d    = lowQual_q;
        zeroBurnt_d  = zeroBurnt_q;
        zero_d       = zero_q;
        stage_d      = stage_q;
        rdData_d     = 8'h00;
        rdValid_d    = regRdEn;
        reload_p_d   = 1'b0;
        burn_p_d     = 1'b0;
        if (regWrEn) begin
            case (regAddr)
                `OTPOS_ADDR_MAXANG_HI: maxAng_d[11:8] = regWrData[3:0];
                `OTPOS_ADDR_MAXANG_LO: maxAng_d[7:0]  = regWrData;
                `OTPOS_ADDR_SETTINGS:  settings_d     = regWrData;
                default: ;
            endcase
            applyCnt_d = APPLY_CYCLES;
        end
        if (cmdWr) begin
            if (regWrData == `OTPOS_CMD_COMMIT) begin
                nvMaxAng_d   = maxAng_q;
                nvSettings_d = settings_q;
            end
            case (reload_q)
                otpos_pkg::RELOAD_IDLE: begin
                    if (regWrData == `OTPOS_CMD_RELOAD_1) begin
                        reload_d = otpos_pkg::RELOAD_GOT1;
                    end
                end
                otpos_pkg::RELOAD_GOT1: begin
                    reload_d = (regWrData == `OTPOS_CMD_RELOAD_2) ? otpos_pkg::RELOAD_GOT2
                             : (regWrData == `OTPOS_CMD_RELOAD_1) ? otpos_pkg::RELOAD_GOT1
                             : otpos_pkg::RELOAD_IDLE;
                end
                otpos_pkg::RELOAD_GOT2: begin
                    if (regWrData == `OTPOS_CMD_RELOAD_3) begin
                        maxAng_d   = nvMaxAng_q;
                        settings_d = nvSettings_q;
                        reload_p_d = 1'b1;
                        reload_d   = otpos_pkg::RELOAD_IDLE;
                    end else begin
                        reload_d = (regWrData == `OTPOS_CMD_RELOAD_1) ? otpos_pkg::RELOAD_GOT1
                                 : otpos_pkg::RELOAD_IDLE;
                    end
                end
                default: reload_d = otpos_pkg::RELOAD_IDLE;
            endcase
        end
        if (applyCnt_q == 32'h1) begin
            stage_d = settings_q[`OTPOS_OSS_MSB:`OTPOS_OSS_LSB];
        end
        // Qualify low pulse, burn on release
        if (!zeroBurnt_q && !pgoLvl_q) begin
            if (!outLvl_q) begin
                if (lowCnt_q >= PIN_LOW_CYCLES - 1) begin
                    lowQual_d = 1'b1;
                end else begin
                    lowCnt_d = lowCnt_q + 32'h1;
                end
            end else begin
                lowCnt_d  = 32'h0;
                lowQual_d = 1'b0;
                if (lowQual_q) begin
                    zero_d      = angleIn;
                    zeroBurnt_d = 1'b1;
                    burn_p_d    = 1'b1;
                end
            end
        end
        pwm_d    = (stage_d == `OTPOS_OSS_PWM);
        dacOff_d = pwm_d;
        if (regRdEn) begin
            case (regAddr)
                `OTPOS_ADDR_ZERO_HI:   rdData_d = {4'h0, zero_q[11:8]};
                `OTPOS_ADDR_ZERO_LO:   rdData_d = zero_q[7:0];
                `OTPOS_ADDR_MAXANG_HI: rdData_d = {4'h0, maxAng_q[11:8]};
                `OTPOS_ADDR_MAXANG_LO: rdData_d = maxAng_q[7:0];
                `OTPOS_ADDR_SETTINGS:  rdData_d = settings_q;
                `OTPOS_ADDR_ANGLE_HI:  rdData_d = {4'h0, angleIn[11:8]};
                `OTPOS_ADDR_ANGLE_LO:  rdData_d = angleIn[7:0];
                default:               rdData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            reload_q     <= otpos_pkg::RELOAD_IDLE;
            // Power-up loads stored content, applied after the delay
            maxAng_q     <= nvMaxAng_q;
            settings_q   <= nvSettings_q;
            applyCnt_q   <= APPLY_CYCLES;
            lowCnt_q     <= 32'h0;
            lowQual_q    <= 1'b0;
            stage_q      <= 2'h0;
            rdData_q     <= 8'h00;
            rdValid_q    <= 1'b0;
            reload_p_q   <= 1'b0;
            burn_p_q     <= 1'b0;
            pwm_q        <= 1'b0;
            dacOff_q     <= 1'b0;
        end else begin
            reload_q     <= reload_d;
            maxAng_q     <= maxAng_d;
            settings_q   <= settings_d;
            nvMaxAng_q   <= nvMaxAng_d;
            nvSettings_q <= nvSettings_d;
            applyCnt_q   <= applyCnt_d;
            lowCnt_q     <= lowCnt_d;
            lowQual_q    <= lowQual_d;
            zeroBurnt_q  <= zeroBurnt_d;
            zero_q       <= zero_d;
            stage_q      <= stage_d;
            rdData_q     <= rdData_d;
            rdValid_q    <= rdValid_d;
            reload_p_q   <= reload_p_d;
            burn_p_q     <= burn_p_d;
            pwm_q        <= pwm_d;
            dacOff_q     <= dacOff_d;
        end
    end

    assign outPinOut         = 1'b0;
    assign outPinOe_n        = ~zeroBurnt_q;
    assign regRdData         = rdData_q;
    assign regRdValid        = rdValid_q;
    assign outputStageSelect = stage_q;
    assign pwmSelect         = pwm_q;
    assign dacPowerDown      = dacOff_q;
    assign reloadPulse       = reload_p_q;
    assign zeroBurnPulse     = burn_p_q;
    assign zeroPosition      = zero_q;

    a_reload_seq_done: assert property (@(posedge mclk) disable iff (srst)
        (cmdWr && regWrData == `OTPOS_CMD_RELOAD_3 && reload_q == otpos_pkg::RELOAD_GOT2)
        |=> reloadPulse && settings_q == $past(nvSettings_q) && maxAng_q == $past(nvMaxAng_q))
        else $error("reload sequence did not reload");
    a_pin_held_low: assert property (@(posedge mclk) disable iff (srst)
        zeroBurnt_q |=> (zeroBurnt_q && !outPinOe_n && !outPinOut)[*2])
        else $error("burnt zero released output pin");
    a_apply_no_early: assert property (@(posedge mclk) disable iff (srst)
        $changed(stage_q) |-> $past(applyCnt_q) == 32'h1)
        else $error("output stage changed before apply delay");
    a_stage_pwm_sel: assert property (@(posedge mclk) disable iff (srst)
        (applyCnt_q == 32'h1 && settings_q[5:4] == 2'h2 && !regWrEn) |=> pwmSelect)
        else $error("PWM stage not selected");
    a_dac_pwm_off: assert property (@(posedge mclk) disable iff (srst)
        pwmSelect |-> dacPowerDown && stage_q == `OTPOS_OSS_PWM)
        else $error("DAC powered in PWM mode");
    a_angle_read_any: assert property (@(posedge mclk) disable iff (srst)
        (regRdEn && regAddr == `OTPOS_ADDR_ANGLE_LO) |=> regRdValid
        && regRdData == $past(angleIn[7:0]))
        else $error("angle read returned wrong value");
    a_zero_capture: assert property (@(posedge mclk) disable iff (srst)
        (lowQual_q && outLvl_q && !zeroBurnt_q && !pgoLvl_q)
        |=> zeroBurnPulse && zeroPosition == $past(angleIn))
        else $error("zero position not captured on release");
endmodule

/* File: sim/otpos_fixture.sv */
// Purpose: Programming fixture on the output pin
// Assumes: Internal pull-up holds the released pin high
// Notes:   Bench sets pullLow to ground the pin
`timescale 1ns/1ns
module otpos_fixture (
    input  wire logic outPinOut,
    input  wire logic outPinOe_n,
    input  wire logic pullLow,
    output logic      outPinIn,
    output logic      programOptionPin
);
    assign programOptionPin = 1'b0;
    // fixture pulls low, then floats
    // Floating pin reads the pull-up, never a stale level
    assign outPinIn = !outPinOe_n ? outPinOut : !pullLow;
endmodule

/* File: sim/tb_otp_programming_output_select.sv */
// Purpose: Self-checking bench for otpos_core
// Assumes: Short apply and pin-filter counts
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ns
`include "otpos_cfg.svh"
module tb_otp_programming_output_select;
    localparam int AP = 20;
    localparam int PL = 16;
    localparam logic [7:0] BC = `OTPOS_ADDR_BURN_CMD;
    localparam logic [7:0] SA = `OTPOS_ADDR_SETTINGS;
    logic        mclk, srst, regWrEn, regRdEn, outPinIn, programOptionPin;
    logic [7:0]  regAddr, regWrData, regRdData, rd, s;
    logic [11:0] angleIn, zeroPosition, ma, zp;
    logic        regRdValid, outPinOut, outPinOe_n, pwmSelect, dacPowerDown;
    logic        reloadPulse, zeroBurnPulse, pullLow;
    logic [1:0]  outputStageSelect, prev;
    int          n_mismatch, tests_run, nReload, nBurn;
    otpos_core #(.APPLY_CYCLES(AP), .PIN_LOW_CYCLES(PL)) uut (
        .mclk, .srst, .regWrEn, .regRdEn, .regAddr, .regWrData, .angleIn,
        .outPinIn, .programOptionPin, .regRdData, .regRdValid, .outPinOut,
        .outPinOe_n, .outputStageSelect, .pwmSelect, .dacPowerDown,
        .reloadPulse, .zeroBurnPulse, .zeroPosition
    );
    otpos_fixture fix (.outPinOut, .outPinOe_n, .pullLow, .outPinIn, .programOptionPin);
    function automatic logic [11:0] hiOf(input logic [11:0] v);
        return {8'h00, v[11:8]};
    endfunction
    function automatic logic [11:0] loOf(input logic [11:0] v);
        return {4'h0, v[7:0]};
    endfunction
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge mclk);
        regWrEn = 1'b0;
    endtask
    task automatic rdb(input logic [7:0] a);
        @(negedge mclk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge mclk);
        regRdEn = 1'b0;
        chk("rdValid", 12'h001, {11'h000, regRdValid});
        rd = regRdData;
    endtask
    task automatic pulse(input int n);
        @(negedge mclk);
        pullLow = 1'b1;
        repeat (n) @(negedge mclk);
        pullLow = 1'b0;
    endtask
    task automatic summarize;
        $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        nReload += (reloadPulse === 1'b1);
        nBurn += (zeroBurnPulse === 1'b1);
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end
    initial begin
        {regWrEn, regRdEn, regAddr, regWrData, angleIn, pullLow} = '0;
        srst = 1'b1;
        {n_mismatch, tests_run, nReload, nBurn} = '0;
        void'($urandom(86103));
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        repeat (3) @(negedge mclk);
        chk("oeRst", 12'h001, {11'h000, outPinOe_n});
        prev = 2'h0;
        for (int i = 0; i < 3; i++) begin
            s = (8'($urandom) & 8'hcf) | {2'h0, 2'((i + 1) % 3), 4'h0};
            wr(SA, s);
            repeat (AP - 1) @(negedge mclk);
            chk("stageEarly", {10'h000, prev}, {10'h000, outputStageSelect});
            @(negedge mclk);
            chk("stage", {10'h000, s[5:4]}, {10'h000, outputStageSelect});
            chk("pwm", {11'h000, s[5:4] == 2'h2}, {11'h000, pwmSelect});
            chk("dac", {11'h000, s[5:4] == 2'h2}, {11'h000, dacPowerDown});
            prev = s[5:4];
        end
        ma = 12'($urandom);
        wr(`OTPOS_ADDR_MAXANG_HI, 8'(hiOf(ma)));
        wr(`OTPOS_ADDR_MAXANG_LO, ma[7:0]);
        s = 8'($urandom);
        wr(SA, s);
        wr(BC, `OTPOS_CMD_COMMIT);
        repeat (AP + 5) @(negedge mclk);
        wr(`OTPOS_ADDR_MAXANG_HI, 8'(hiOf(~ma)));
        wr(`OTPOS_ADDR_MAXANG_LO, ~ma[7:0]);
        wr(BC, `OTPOS_CMD_RELOAD_1);
        wr(BC, 8'h22);
        wr(BC, `OTPOS_CMD_RELOAD_2);
        wr(BC, `OTPOS_CMD_RELOAD_3);
        repeat (3) @(negedge mclk);
        chk("reloadBroken", 12'h000, 12'(nReload));
        wr(BC, `OTPOS_CMD_RELOAD_1);
        wr(SA, ~s);
        wr(BC, `OTPOS_CMD_RELOAD_2);
        wr(BC, `OTPOS_CMD_RELOAD_3);
        repeat (3) @(negedge mclk);
        chk("reload", 12'h001, 12'(nReload));
        rdb(`OTPOS_ADDR_MAXANG_HI);
        chk("maxHi", hiOf(ma), {4'h0, rd});
        rdb(`OTPOS_ADDR_MAXANG_LO);
        chk("maxLo", loOf(ma), {4'h0, rd});
        rdb(SA);
        chk("settings", {4'h0, s}, {4'h0, rd});
        angleIn = 12'($urandom);
        zp = angleIn;
        pulse(PL / 2);
        repeat (12) @(negedge mclk);
        chk("burnShort", 12'h000, 12'(nBurn));
        chk("oeShort", 12'h001, {11'h000, outPinOe_n});
        pulse(PL + 4);
        repeat (12) @(negedge mclk);
        chk("burn", 12'h001, 12'(nBurn));
        chk("zeroPos", zp, zeroPosition);
        for (int k = 0; k < 6; k++) begin
            angleIn = (k == 0) ? 12'hfff : 12'($urandom);
            rdb(`OTPOS_ADDR_ANGLE_HI);
            chk("angHi", hiOf(angleIn), {4'h0, rd});
            rdb(`OTPOS_ADDR_ANGLE_LO);
            chk("angLo", loOf(angleIn), {4'h0, rd});
            chk("pinLow", 12'h000, {11'h000, outPinIn});
            chk("oeBurnt", 12'h000, {11'h000, outPinOe_n});
        end
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        repeat (2) @(negedge mclk);
        chk("oeCycle", 12'h000, {11'h000, outPinOe_n});
        rdb(`OTPOS_ADDR_MAXANG_HI);
        chk("nvMaxHi", hiOf(ma), {4'h0, rd});
        rdb(`OTPOS_ADDR_MAXANG_LO);
        chk("nvMaxLo", loOf(ma), {4'h0, rd});
        rdb(SA);
        chk("nvSettings", {4'h0, s}, {4'h0, rd});
        rdb(`OTPOS_ADDR_ZERO_HI);
        chk("nvZeroHi", hiOf(zp), {4'h0, rd});
        rdb(`OTPOS_ADDR_ZERO_LO);
        chk("nvZeroLo", loOf(zp), {4'h0, rd});
        repeat (AP) @(negedge mclk);
        chk("stageCycle", {10'h000, s[5:4]}, {10'h000, outputStageSelect});
        summarize();
    end
endmodule
